// *** hdl/tmr_core.sv ***
// 16-bit timer/counter: mode decode, prescaler, capture and registers.
// Assumes a classic Wishbone master and pins synchronous to clk_i.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tmr_core
   import tmr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic capture_input_pin_i,
   input wire logic analog_cmp_i,
   input wire logic external_clock_pin_i,
   input wire logic [3:0] vector_ack_i,
   output logic capture_flag_o,
   output logic compare_flag_a_o,
   output logic compare_flag_b_o,
   output logic overflow_flag_o,
   output logic compare_output_a_o,
   output logic compare_output_b_o,
   output logic [15:0] counter_value_o
);
   // *****************************
   // Registers and decode
   // *****************************
   logic ack_r;
   logic [31:0] dat_r;
   logic [7:0] timer_control_a_r;
   logic [7:0] timer_control_b_r;
   logic [7:0] temp_r;
   logic [15:0] counter_value_r;
   logic [15:0] compare_value_a_r;
   logic [15:0] compare_value_b_r;
   logic [15:0] cmpa_buf_r;
   logic [15:0] cmpb_buf_r;
   logic [15:0] capture_value_r;
   logic capture_src_r;
   logic capture_flag_r;
   logic compare_flag_a_r;
   logic compare_flag_b_r;
   logic overflow_flag_r;
   logic match_a_r;
   logic match_b_r;
   logic block_r;
   logic down_r;
   logic [PRE_W-1:0] pre_r;
   logic ext_s1_r;
   logic ext_s2_r;
   logic ext_d_r;
   logic cap_s1_r;
   logic cap_s2_r;
   logic [FILT_LEN-1:0] filt_sh_r;
   logic filt_r;
   logic filt_d_r;
   logic acc;
   logic wr;
   logic rd;
   logic [7:0] wd;
   logic [3:0] wave_mode_select;
   logic [2:0] clock_source_select;
   logic tick;
   logic [15:0] top;
   tmr_top_e top_src;
   tmr_upd_e upd;
   logic dual_slope;
   logic ovf_at_max;
   logic ovf_at_top;
   logic at_top;
   logic at_bot;
   logic cap_sel;
   logic cap_edge;
   logic cap_event;
   logic cnt_wr;
   logic hit_a;
   logic hit_b;
   logic [3:0] clr;

   assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
   // Byte lane 0 carries every register; other lanes are ignored
   assign wr = acc & wb_we_i & wb_sel_i[0];
   assign rd = acc & ~wb_we_i;
   assign wd = wb_dat_i[7:0];
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign wave_mode_select = {timer_control_b_r[4:3], timer_control_a_r[1:0]};
   assign clock_source_select = timer_control_b_r[2:0];
   assign cnt_wr = wr & (wb_adr_i == TMR_CNT_L);

   // *****************************
   // Mode decode
   // *****************************
   always_comb begin
      top = MAX_VAL;
      top_src = TMR_TOP_FIXED;
      upd = TMR_UPD_NOW;
      dual_slope = 1'b0;
      ovf_at_max = 1'b0;
      ovf_at_top = 1'b0;
      case (wave_mode_select)
         4'd0: begin
            ovf_at_max = 1'b1;
         end
         4'd1, 4'd2, 4'd3, 4'd10, 4'd11: begin
            upd = TMR_UPD_TOP;
            dual_slope = 1'b1;
         end
         4'd4, 4'd12: begin
            ovf_at_max = 1'b1;
         end
         4'd5, 4'd6, 4'd7, 4'd14, 4'd15: begin
            upd = TMR_UPD_BOT;
            ovf_at_top = 1'b1;
         end
         4'd8, 4'd9: begin
            upd = TMR_UPD_BOT;
            dual_slope = 1'b1;
         end
         default: begin
            ovf_at_max = 1'b1;
         end
      endcase
      case (wave_mode_select)
         4'd1, 4'd5: top = TOP_8;
         4'd2, 4'd6: top = TOP_9;
         4'd3, 4'd7: top = TOP_10;
         4'd4, 4'd9, 4'd11, 4'd15: top_src = TMR_TOP_CMPA;
         4'd8, 4'd10, 4'd12, 4'd14: top_src = TMR_TOP_CAP;
         default: top = MAX_VAL;
      endcase
      case (top_src)
         TMR_TOP_CMPA: top = compare_value_a_r;
         TMR_TOP_CAP: top = capture_value_r;
         default: top = top;
      endcase
   end

   assign at_top = counter_value_r == top;
   assign at_bot = counter_value_r == BOTTOM;

   // *****************************
   // Clock select and prescaler
   // *****************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 1'b1;
      end
   end

   // Pin state is sampled only, so the pin's own direction never matters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_d_r <= 1'b0;
      end else begin
         ext_s1_r <= external_clock_pin_i;
         ext_s2_r <= ext_s1_r;
         ext_d_r <= ext_s2_r;
      end
   end

   always_comb begin
      case (clock_source_select)
         CS_STOP: tick = 1'b0;
         CS_DIV1: tick = 1'b1;
         CS_DIV8: tick = &pre_r[2:0];
         CS_DIV64: tick = &pre_r[5:0];
         CS_DIV256: tick = &pre_r[7:0];
         CS_DIV1024: tick = &pre_r[9:0];
         CS_EXT_FALL: tick = ext_d_r & ~ext_s2_r;
         CS_EXT_RISE: tick = ~ext_d_r & ext_s2_r;
         default: tick = 1'b0;
      endcase
   end

   // *****************************
   // Counter
   // *****************************
   // A bus write wins over a timer tick in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter_value_r <= '0;
         down_r <= 1'b0;
      end else if (cnt_wr) begin
         counter_value_r <= {temp_r, wd};
      end else if (tick) begin
         if (!dual_slope) begin
            down_r <= 1'b0;
            counter_value_r <= at_top ? BOTTOM : counter_value_r + 1'b1;
         end else if (!down_r) begin
            down_r <= at_top;
            counter_value_r <= at_top ? counter_value_r - 1'b1 : counter_value_r + 1'b1;
         end else begin
            down_r <= ~at_bot;
            counter_value_r <= at_bot ? counter_value_r + 1'b1 : counter_value_r - 1'b1;
         end
      end
   end
   assign counter_value_o = counter_value_r;

   // *****************************
   // Compare units
   // *****************************
   // Block lasts until the next timer tick after the counter write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         block_r <= 1'b0;
      end else if (cnt_wr) begin
         block_r <= 1'b1;
      end else if (tick) begin
         block_r <= 1'b0;
      end
   end

   assign hit_a = tick & ~block_r & (counter_value_r == compare_value_a_r);
   assign hit_b = tick & ~block_r & (counter_value_r == compare_value_b_r);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_a_r <= 1'b0;
         match_b_r <= 1'b0;
      end else begin
         match_a_r <= hit_a;
         match_b_r <= hit_b;
      end
   end
   assign compare_output_a_o = match_a_r;
   assign compare_output_b_o = match_b_r;

   // Double buffers; immediate modes copy the buffer every cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_value_a_r <= '0;
         compare_value_b_r <= '0;
      end else if ((upd == TMR_UPD_NOW) ||
                   (tick && upd == TMR_UPD_TOP && at_top && !down_r) ||
                   (tick && upd == TMR_UPD_BOT && !dual_slope && at_top) ||
                   (tick && upd == TMR_UPD_BOT && dual_slope && at_bot && down_r)) begin
         compare_value_a_r <= cmpa_buf_r;
         compare_value_b_r <= cmpb_buf_r;
      end
   end

   // *****************************
   // Capture input
   // *****************************
   assign cap_sel = capture_src_r ? analog_cmp_i : capture_input_pin_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_s1_r <= 1'b0;
         cap_s2_r <= 1'b0;
         filt_sh_r <= '0;
         filt_r <= 1'b0;
         filt_d_r <= 1'b0;
      end else begin
         cap_s1_r <= cap_sel;
         cap_s2_r <= cap_s1_r;
         filt_sh_r <= {filt_sh_r[FILT_LEN-2:0], cap_s2_r};
         if (!timer_control_b_r[CB_FILT]) begin
            filt_r <= cap_s2_r;
         end else if (&filt_sh_r || ~|filt_sh_r) begin
            filt_r <= filt_sh_r[FILT_LEN-1];
         end
         filt_d_r <= filt_r;
      end
   end

   assign cap_edge = timer_control_b_r[CB_EDGE] ? (filt_r & ~filt_d_r)
                                               : (~filt_r & filt_d_r);
   assign cap_event = cap_edge & (top_src != TMR_TOP_CAP);

   // *****************************
   // Flags
   // *****************************
   // Set beats clear when both land in one cycle
   assign clr = vector_ack_i | ({4{wr & (wb_adr_i == TMR_FLAGS)}} &
                {wd[FL_CAP], wd[FL_CMPA], wd[FL_CMPB], wd[FL_OVF]});

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_flag_r <= 1'b0;
         compare_flag_a_r <= 1'b0;
         compare_flag_b_r <= 1'b0;
         overflow_flag_r <= 1'b0;
      end else begin
         if (cap_event || (tick && top_src == TMR_TOP_CAP && at_top && !down_r)) begin
            capture_flag_r <= 1'b1;
         end else if (clr[3]) begin
            capture_flag_r <= 1'b0;
         end
         if (hit_a) begin
            compare_flag_a_r <= 1'b1;
         end else if (clr[2]) begin
            compare_flag_a_r <= 1'b0;
         end
         if (hit_b) begin
            compare_flag_b_r <= 1'b1;
         end else if (clr[1]) begin
            compare_flag_b_r <= 1'b0;
         end
         if (tick && ((ovf_at_max && counter_value_r == MAX_VAL) ||
                      (ovf_at_top && at_top) ||
                      (dual_slope && at_bot && down_r))) begin
            overflow_flag_r <= 1'b1;
         end else if (clr[0]) begin
            overflow_flag_r <= 1'b0;
         end
      end
   end
   assign capture_flag_o = capture_flag_r;
   assign compare_flag_a_o = compare_flag_a_r;
   assign compare_flag_b_o = compare_flag_b_r;
   assign overflow_flag_o = overflow_flag_r;

   // *****************************
   // Capture register
   // *****************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_value_r <= '0;
      end else if (wr && wb_adr_i == TMR_CAP_L) begin
         capture_value_r <= {temp_r, wd};
      end else if (cap_event) begin
         capture_value_r <= counter_value_r;
      end
   end

   // *****************************
   // Bus writes
   // *****************************
   // Reserved bit 5 of control B is not stored and reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_control_a_r <= CTRL_RST;
         timer_control_b_r <= CTRL_RST;
         cmpa_buf_r <= '0;
         cmpb_buf_r <= '0;
         capture_src_r <= 1'b0;
      end else if (wr) begin
         case (wb_adr_i)
            TMR_CTRL_A: timer_control_a_r <= wd & CTRL_A_RW;
            TMR_CTRL_B: timer_control_b_r <= wd & CTRL_B_RW;
            TMR_CMPA_L: cmpa_buf_r <= {temp_r, wd};
            TMR_CMPB_L: cmpb_buf_r <= {temp_r, wd};
            TMR_SRC: capture_src_r <= wd[0];
            default: capture_src_r <= capture_src_r;
         endcase
      end
   end

   // *****************************
   // Shared high byte and reads
   // *****************************
   // High byte written first, low byte read first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         temp_r <= '0;
      end else if (wr && (wb_adr_i == TMR_CNT_H || wb_adr_i == TMR_CMPA_H ||
                          wb_adr_i == TMR_CMPB_H || wb_adr_i == TMR_CAP_H)) begin
         temp_r <= wd;
      end else if (rd && wb_adr_i == TMR_CNT_L) begin
         temp_r <= counter_value_r[15:8];
      end else if (rd && wb_adr_i == TMR_CAP_L) begin
         temp_r <= capture_value_r[15:8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= '0;
      end else begin
         ack_r <= acc;
         if (rd) begin
            dat_r <= '0;
            case (wb_adr_i)
               TMR_CTRL_A: dat_r[7:0] <= timer_control_a_r;
               TMR_CTRL_B: dat_r[7:0] <= timer_control_b_r;
               TMR_CNT_L: dat_r[7:0] <= counter_value_r[7:0];
               TMR_CMPA_L: dat_r[7:0] <= cmpa_buf_r[7:0];
               TMR_CMPA_H: dat_r[7:0] <= cmpa_buf_r[15:8];
               TMR_CMPB_L: dat_r[7:0] <= cmpb_buf_r[7:0];
               TMR_CMPB_H: dat_r[7:0] <= cmpb_buf_r[15:8];
               TMR_CAP_L: dat_r[7:0] <= capture_value_r[7:0];
               TMR_CNT_H, TMR_CAP_H: dat_r[7:0] <= temp_r;
               TMR_FLAGS: dat_r[7:0] <= {2'b00, capture_flag_r, compare_flag_a_r,
                                         compare_flag_b_r, overflow_flag_r, 2'b00};
               TMR_SRC: dat_r[7:0] <= {7'h00, capture_src_r};
               default: dat_r <= '0;
            endcase
         end
      end
   end
endmodule : tmr_core
`default_nettype wire

// *** common/tmr_pkg.sv ***
// Constants of the 16-bit timer/counter register block.
// Assumes a 32-bit classic Wishbone slave port, one byte per word.
package tmr_pkg;
   // *****************************
   // Register byte addresses
   // *****************************
   localparam logic [7:0] TMR_CTRL_A = 8'h00;
   localparam logic [7:0] TMR_CTRL_B = 8'h04;
   localparam logic [7:0] TMR_CNT_L = 8'h08;
   localparam logic [7:0] TMR_CNT_H = 8'h0c;
   localparam logic [7:0] TMR_CMPA_L = 8'h10;
   localparam logic [7:0] TMR_CMPA_H = 8'h14;
   localparam logic [7:0] TMR_CMPB_L = 8'h18;
   localparam logic [7:0] TMR_CMPB_H = 8'h1c;
   localparam logic [7:0] TMR_CAP_L = 8'h20;
   localparam logic [7:0] TMR_CAP_H = 8'h24;
   localparam logic [7:0] TMR_FLAGS = 8'h28;
   localparam logic [7:0] TMR_SRC = 8'h2c;
   // *****************************
   // Field positions and resets
   // *****************************
   localparam int CB_FILT = 7;
   localparam int CB_EDGE = 6;
   localparam int CB_RSVD = 5;
   localparam int FL_CAP = 5;
   localparam int FL_CMPA = 4;
   localparam int FL_CMPB = 3;
   localparam int FL_OVF = 2;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL_A_RW = 8'hf3;
   localparam logic [7:0] CTRL_B_RW = 8'hdf;
   localparam logic [15:0] MAX_VAL = 16'hffff;
   localparam logic [15:0] TOP_8 = 16'h00ff;
   localparam logic [15:0] TOP_9 = 16'h01ff;
   localparam logic [15:0] TOP_10 = 16'h03ff;
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam int FILT_LEN = 4;
   localparam int PRE_W = 10;
   // *****************************
   // Clock source codes
   // *****************************
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   typedef enum logic [1:0] {TMR_TOP_FIXED, TMR_TOP_CMPA, TMR_TOP_CAP} tmr_top_e;
   typedef enum logic [1:0] {TMR_UPD_NOW, TMR_UPD_TOP, TMR_UPD_BOT} tmr_upd_e;
endpackage : tmr_pkg

// *** tb/tmr_pins.sv ***
// Pin-side partner: capture pin, comparator output and count pin.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tmr_pins (
   input wire logic clk_i,
   output logic cap_o,
   output logic cmp_o,
   output logic ext_o
);
   initial begin
      cap_o = 1'b0;
      cmp_o = 1'b0;
      ext_o = 1'b0;
   end
   // ****
   // Levels are held for n cycles so the synchroniser sees them
   // ****
   task automatic drive(input int p, input logic v, input int n);
      @(posedge clk_i);
      if (p == 0) begin
         cap_o <= v;
      end else begin
         cmp_o <= v;
      end
      repeat (n) @(posedge clk_i);
   endtask : drive
   // Pin toggled as by software, no port direction is modelled
   task automatic ext_pulse(input int n);
      repeat (n) begin
         @(posedge clk_i);
         ext_o <= 1'b1;
         repeat (6) @(posedge clk_i);
         ext_o <= 1'b0;
         repeat (6) @(posedge clk_i);
      end
   endtask : ext_pulse
endmodule : tmr_pins
`default_nettype wire

// *** tb/tmr_core_sva.sv ***
// Port checker of the timer core, bound to every instance.
// Assumes control writes are only taken while ack is low.
`timescale 1ns/1ps
`default_nettype none
module tmr_core_sva
   import tmr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [3:0] vector_ack_i,
   input wire logic compare_flag_a_o,
   input wire logic overflow_flag_o,
   input wire logic [15:0] counter_value_o
);
   // ****
   // Shadow of the control registers
   // ****
   logic [7:0] ca_r;
   logic [7:0] cb_r;
   logic take;
   logic cntw;
   logic flgw;
   logic mode0;
   logic run1;
   assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   assign cntw = take && (wb_adr_i == TMR_CNT_L);
   assign flgw = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == TMR_FLAGS);
   assign mode0 = (ca_r[1:0] == 2'h0) && (cb_r[4:3] == 2'h0);
   assign run1 = mode0 && (cb_r[2:0] == CS_DIV1) && !cntw;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ca_r <= 8'h00;
         cb_r <= 8'h00;
      end else if (take && wb_adr_i == TMR_CTRL_A) begin
         ca_r <= wb_dat_i[7:0];
      end else if (take && wb_adr_i == TMR_CTRL_B) begin
         cb_r <= wb_dat_i[7:0];
      end
   end
   default clocking dcb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   AST_ACK_ONE: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   AST_DAT_UPPER: assert property (
      wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper data set");
   AST_STOP_HOLD: assert property (
      cb_r[2:0] == CS_STOP && !cntw |=> $stable(counter_value_o))
      else $error("stopped counter moved");
   AST_DIV1_INC: assert property (
      run1 [*2] |=> counter_value_o == $past(counter_value_o) + 16'h0001)
      else $error("counter not stepping");
   AST_OVF_MAX: assert property (
      run1 [*2] ##0 counter_value_o == MAX_VAL |=> overflow_flag_o)
      else $error("overflow not set at max");
   AST_OVF_ONLY_MAX: assert property (
      mode0 && !overflow_flag_o && counter_value_o != MAX_VAL |=> !overflow_flag_o)
      else $error("overflow set early");
   AST_CMPA_HOLD: assert property (
      compare_flag_a_o && !vector_ack_i[2] && !flgw |=> compare_flag_a_o)
      else $error("compare flag lost");
   AST_VEC_CLR: assert property (
      vector_ack_i[2] && cb_r[2:0] == CS_STOP |=> !compare_flag_a_o)
      else $error("vector did not clear");
endmodule : tmr_core_sva
bind tmr_core tmr_core_sva tmr_core_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .vector_ack_i(vector_ack_i), .compare_flag_a_o(compare_flag_a_o),
   .overflow_flag_o(overflow_flag_o), .counter_value_o(counter_value_o));
`default_nettype wire

// *** tb/tmr_core_tb.sv ***
// Self-checking bench of the timer core over classic Wishbone.
// Assumes the core acks one cycle after a request is taken.
`timescale 1ns/1ps
`default_nettype none
module tmr_core_tb
   import tmr_pkg::*;
;
   typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} tmr_row_s;
   localparam tmr_row_s ROWS [7] = '{'{8'h00, 8'hff, 8'hf3}, '{8'h00, 8'h00, 8'h00},
      '{8'h04, 8'hd8, 8'hd8}, '{8'h04, 8'h00, 8'h00}, '{8'h2c, 8'h01, 8'h01},
      '{8'h2c, 8'h00, 8'h00}, '{8'h30, 8'ha5, 8'h00}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [3:0] vack = 4'h0;
   logic [31:0] dat_o;
   logic ack, cap, cmp, ext, oa, ob, pa, pb;
   logic [5:0] flg;
   logic [15:0] cnt;
   int n_fail = 0;
   int tests_run = 0;
   initial forever #50 clk = ~clk;
   tmr_core tmr_core_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .capture_input_pin_i(cap), .analog_cmp_i(cmp),
      .external_clock_pin_i(ext), .vector_ack_i(vack), .capture_flag_o(flg[5]),
      .compare_flag_a_o(flg[4]), .compare_flag_b_o(flg[3]), .overflow_flag_o(flg[2]),
      .compare_output_a_o(oa), .compare_output_b_o(ob), .counter_value_o(cnt));
   tmr_pins tmr_pins_inst (.clk_i(clk), .cap_o(cap), .cmp_o(cmp), .ext_o(ext));
   assign flg[1:0] = 2'h0;
   initial {pa, pb} = 2'b00;
   always @(posedge clk) if (oa === 1'b1) pa <= 1'b1;
   // Match pulses last one cycle, so they are latched for a later look
   always @(posedge clk) if (ob === 1'b1) pb <= 1'b1;
   // ****
   // Checking and bus tasks
   // ****
   task automatic close_out();
      if (n_fail == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
      output logic [7:0] q);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      do begin
         @(posedge clk);
         k++;
         if (k > 20) begin
            n_fail++;
            close_out();
         end
      end while (ack !== 1'b1);
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(a, 1'b1, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      wb(a, 1'b0, 8'h00, q);
   endtask : rd
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a + 8'h04, v[15:8]);
      wr(a, v[7:0]);
   endtask : wr16
   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      rd(a, v[7:0]);
      rd(a + 8'h04, v[15:8]);
   endtask : rd16
   task automatic waitf(input int s, input int lim);
      int k;
      k = 0;
      while (flg[s] !== 1'b1) begin
         @(posedge clk);
         k++;
         if (k > lim) begin
            n_fail++;
            close_out();
         end
      end
   endtask : waitf
   // ****
   // Main sequence
   // ****
   initial begin
      logic [7:0] q;
      logic [15:0] v;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(TMR_FLAGS, q);
      chk({8'h00, q}, 16'h0000);
      foreach (ROWS[i]) begin
         wr(ROWS[i].a, ROWS[i].w);
         rd(ROWS[i].a, q);
         chk({8'h00, q}, {8'h00, ROWS[i].e});
      end
      wr16(TMR_CNT_L, 16'h1234);
      rd16(TMR_CNT_L, v);
      chk(v, 16'h1234);
      wr16(TMR_CMPB_L, 16'h8000);
      wr16(TMR_CMPA_L, 16'h0040);
      rd16(TMR_CMPA_L, v);
      chk(v, 16'h0040);
      wr16(TMR_CNT_L, 16'hfff0);
      wr(TMR_CTRL_B, {5'h00, CS_DIV1});
      waitf(FL_OVF, 40);
      wr(TMR_CTRL_B, 8'h00);
      rd(TMR_FLAGS, q);
      chk({8'h00, q}, 16'h0004);
      wr(TMR_FLAGS, 8'h04);
      rd(TMR_FLAGS, q);
      chk({8'h00, q}, 16'h0000);
      wr16(TMR_CNT_L, 16'h0030);
      wr(TMR_CTRL_B, {5'h00, CS_DIV1});
      waitf(FL_CMPA, 40);
      chk(cnt, 16'h0041);
      wr(TMR_CTRL_B, 8'h00);
      chk({15'h0, pa}, 16'h0001);
      vack <= 4'h4;
      @(posedge clk);
      vack <= 4'h0;
      @(posedge clk);
      chk({15'h0, flg[FL_CMPA]}, 16'h0000);
      wr16(TMR_CMPB_L, 16'h0050);
      wr16(TMR_CNT_L, 16'h0050);
      wr(TMR_CTRL_B, {5'h00, CS_DIV1});
      wr(TMR_CTRL_B, 8'h00);
      chk({15'h0, flg[FL_CMPB]}, 16'h0000);
      chk({15'h0, pb}, 16'h0000);
      wr16(TMR_CNT_L, 16'h0777);
      wr(TMR_CTRL_B, 8'h40);
      tmr_pins_inst.drive(0, 1'b1, 10);
      waitf(FL_CAP, 10);
      rd16(TMR_CAP_L, v);
      chk(v, 16'h0777);
      wr(TMR_FLAGS, 8'h20);
      tmr_pins_inst.drive(0, 1'b0, 10);
      chk({15'h0, flg[FL_CAP]}, 16'h0000);
      wr(TMR_CTRL_B, 8'h00);
      wr16(TMR_CNT_L, 16'h0888);
      tmr_pins_inst.drive(0, 1'b1, 10);
      chk({15'h0, flg[FL_CAP]}, 16'h0000);
      tmr_pins_inst.drive(0, 1'b0, 2);
      waitf(FL_CAP, 10);
      rd16(TMR_CAP_L, v);
      chk(v, 16'h0888);
      wr(TMR_FLAGS, 8'h20);
      wr(TMR_CTRL_B, 8'hc0);
      tmr_pins_inst.drive(0, 1'b1, 1);
      tmr_pins_inst.drive(0, 1'b0, 10);
      chk({15'h0, flg[FL_CAP]}, 16'h0000);
      tmr_pins_inst.drive(0, 1'b1, 10);
      chk({15'h0, flg[FL_CAP]}, 16'h0001);
      wr(TMR_FLAGS, 8'h20);
      wr(TMR_SRC, 8'h01);
      wr(TMR_CTRL_B, 8'h40);
      tmr_pins_inst.drive(1, 1'b1, 10);
      chk({15'h0, flg[FL_CAP]}, 16'h0001);
      wr(TMR_SRC, 8'h00);
      wr(TMR_FLAGS, 8'h20);
      wr(TMR_CTRL_B, 8'h58);
      tmr_pins_inst.drive(0, 1'b0, 10);
      tmr_pins_inst.drive(0, 1'b1, 10);
      chk({15'h0, flg[FL_CAP]}, 16'h0000);
      wr(TMR_CTRL_B, 8'h00);
      wr16(TMR_CNT_L, 16'h0000);
      wr(TMR_CTRL_B, {5'h00, CS_EXT_RISE});
      tmr_pins_inst.ext_pulse(3);
      chk(cnt, 16'h0003);
      wr(TMR_CTRL_B, {5'h00, CS_EXT_FALL});
      tmr_pins_inst.ext_pulse(2);
      chk(cnt, 16'h0005);
      for (int i = 2; i < 6; i++) begin
         wr(TMR_CTRL_B, 8'h00);
         wr16(TMR_CNT_L, 16'h0000);
         wr(TMR_CTRL_B, {5'h00, 3'(i)});
         // About four ticks of divide by 8, 64, 256 and 1024
         repeat (4 << (i == 2 ? 3 : (i == 3 ? 6 : (i == 4 ? 8 : 10)))) @(posedge clk);
         wr(TMR_CTRL_B, 8'h00);
         chk({15'h0, cnt >= 16'h0003 && cnt <= 16'h0005}, 16'h0001);
      end
      // Fast PWM wraps at its fixed top, phase correct turns there
      for (int m = 0; m < 2; m++) begin
         wr(TMR_CTRL_B, 8'h00);
         wr(TMR_FLAGS, 8'h3c);
         wr(TMR_CTRL_A, 8'h01);
         wr16(TMR_CNT_L, 16'h0000);
         wr(TMR_CTRL_B, m == 1 ? 8'h09 : 8'h01);
         waitf(FL_OVF, 600);
         chk({15'h0, cnt <= 16'h0001}, 16'h0001);
      end
      chk({15'h0, pb}, 16'h0001);
      close_out();
   end
endmodule : tmr_core_tb
`default_nettype wire
